// ---- bench/sector_lock_checker.sv ----
// port assertions for the sector protection lock block
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module sector_lock_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic so_oe,
  input wire logic protection_lock_bit,
  input wire logic [1:0] protection_summary_bits,
  input wire logic hw_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // three locked cycles cover the lag of the summary
  sequence hw_hold;
    (!wp_n && hw_locked) [*3];
  endsequence
  a_reset_values: assert property ($past(rst) |->
    protection_summary_bits == 2'h3 && !protection_lock_bit && !hw_locked)
    else $error("bad reset state");
  a_hw_needs_pin: assert property ($past(wp_n) |-> !hw_locked)
    else $error("lock with pin high");
  a_hw_from_lock: assert property (!$past(wp_n) && !wp_n &&
    $past(protection_lock_bit) && protection_lock_bit |-> hw_locked)
    else $error("lock missing");
  a_lock_held: assert property (hw_locked && !wp_n |=>
    protection_lock_bit) else $error("lock bit cleared");
  a_prot_frozen: assert property (hw_hold |->
    $stable(protection_summary_bits)) else $error("protection moved");
  a_cs_float: assert property (cs_n && $past(cs_n) |-> !so_oe)
    else $error("output while deselected");
  a_oe_on_fall: assert property ($rose(so_oe) |->
    !$past(sck) && !$past(cs_n)) else $error("output off edge");
  a_lock_by_spi: assert property ($changed(protection_lock_bit) |->
    !$past(cs_n, 2) && $past(sck, 2)) else $error("lock off frame");
endmodule
bind sector_protection_lock sector_lock_checker sector_lock_checker_inst (
  .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .wp_n(wp_n),
  .so_oe(so_oe), .protection_lock_bit(protection_lock_bit),
  .protection_summary_bits(protection_summary_bits), .hw_locked(hw_locked));
`default_nettype wire

// ---- bench/spi_host_model.sv ----
// spi mode 0 host giving byte transfers to the bench
// assumes so is valid only while the block enables it
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial {sck, cs_n, si} = 3'h2;
  task automatic start();
    @(posedge clk) cs_n <= 1'b0;
  endtask
  // long low phase leaves room for the registered output
  task automatic xfer(input logic [7:0] tx, input int nb,
    output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--)
    begin
      @(posedge clk) si <= tx[i];
      sck <= 1'b0;
      repeat (2) @(posedge clk);
      @(posedge clk) sck <= 1'b1;
      // an undriven line reads as the inverse of its last level
      rx[i] = so_oe ? so : ~so;
      @(posedge clk);
    end
  endtask
  // release at any bit; data line scrambled once deselected
  task automatic stop();
    @(posedge clk) cs_n <= 1'b1;
    sck <= 1'b0;
    si <= ~si;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/test_sector_protection_lock.sv ----
// self-checking bench for the sector protection lock block
// assumes the host model drives the spi pins of the block
`timescale 1ns/1ps
`default_nettype none
module test_sector_protection_lock;
  localparam logic [7:0] OP_WS = 8'h01;
  localparam logic [7:0] OP_PS = 8'h36;
  localparam logic [7:0] OP_US = 8'h39;
  localparam logic [7:0] OP_RD = sector_lock_pkg::OP_READ_PROTECTION;
  logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1;
  logic [7:0] rx;
  wire logic sck, cs_n, si, so, oe, lock, hw;
  wire logic [1:0] sum;
  int err_total = 0, samples_checked = 0;
  always #10 clk = ~clk;
  sector_protection_lock #(.OP_WRITE_STATUS(OP_WS),
    .OP_PROTECT_SECTOR(OP_PS), .OP_UNPROTECT_SECTOR(OP_US))
    sector_protection_lock_inst (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(oe),
    .protection_lock_bit(lock), .protection_summary_bits(sum),
    .hw_locked(hw));
  spi_host_model spi_host_model_inst (.clk(clk), .so(so), .so_oe(oe),
    .sck(sck), .cs_n(cs_n), .si(si));
  task automatic ck(input string n, input logic [7:0] s, e);
    samples_checked++;
    err_total += int'(s !== e);
    if (s !== e)
      $display("unexpected %s expected %h seen %h", n, e, s);
  endtask
  // state byte: lock, hardware lock, two summary bits
  task automatic st(input logic [7:0] e);
    repeat (4) @(posedge clk);
    ck("state", {4'h0, lock, hw, sum}, e);
  endtask
  task automatic tx(input logic [7:0] b);
    spi_host_model_inst.xfer(b, 8, rx);
  endtask
  task automatic ws(input logic [7:0] v);
    spi_host_model_inst.start();
    tx(OP_WS);
    tx(v);
    spi_host_model_inst.stop();
  endtask
  // junk in the upper and low address bits must not matter
  task automatic ac(input logic [7:0] op, input logic [4:0] s);
    spi_host_model_inst.start();
    tx(op);
    tx({3'h7, s});
    tx(8'hA5);
    tx(8'h5A);
  endtask
  task automatic sc(input logic [7:0] op, input logic [4:0] s);
    ac(op, s);
    spi_host_model_inst.stop();
  endtask
  task automatic rd(input logic [4:0] s, input logic [7:0] e);
    ac(OP_RD, s);
    repeat (2)
    begin
      tx(8'h00);
      ck("prot", rx, e);
    end
    spi_host_model_inst.stop();
    ck("so_oe", {7'h00, oe}, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    st(8'h03);
    rd(5'h05, 8'hFF);
    ws(8'h00);
    st(8'h00);
    rd(5'h04, 8'h00);
    ws(8'h7F);
    st(8'h03);
    sc(OP_US, 5'h03);
    st(8'h01);
    rd(5'h03, 8'h00);
    ws(8'hFF);
    st(8'h0B);
    sc(OP_US, 5'h04);
    st(8'h0B);
    ws(8'h00);
    st(8'h03);
    sc(OP_US, 5'h03);
    st(8'h01);
    wp_n <= 1'b0;
    ws(8'hF0);
    st(8'h0D);
    rd(5'h03, 8'h00);
    sc(OP_PS, 5'h03);
    ws(8'h00);
    st(8'h0D);
    wp_n <= 1'b1;
    st(8'h09);
    ac(OP_RD, 5'h03);
    spi_host_model_inst.xfer(8'h00, 3, rx);
    spi_host_model_inst.stop();
    ck("so_oe", {7'h00, oe}, 8'h00);
    rd(5'h04, 8'hFF);
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- core/sector_lock_pkg.sv ----
// shared constants and carrier types for the sector protection lock block
// assumes a single 50 MHz clock and spi pins already synchronous to it
package sector_lock_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int SECTOR_COUNT = 32;
  localparam int SECTOR_IDX_W = 5;
  localparam int BYTE_W = 8;
  localparam int ADDR_BYTES = 3;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_PROTECTION = 8'h3C;

  // ----------------------------------------------------------------
  // first status byte layout
  // ----------------------------------------------------------------
  localparam int LOCK_BIT_POS = 7;
  localparam int GLOBAL_MSB = 5;
  localparam int GLOBAL_LSB = 2;
  localparam logic [3:0] GLOBAL_UNPROTECT_CODE = 4'h0;
  localparam logic [3:0] GLOBAL_PROTECT_CODE = 4'hF;

  // ----------------------------------------------------------------
  // reset values and summary encodings
  // ----------------------------------------------------------------
  localparam logic LOCK_RESET = 1'b0;
  localparam logic SECTOR_PROT_RESET = 1'b1;
  localparam logic [1:0] SUMMARY_NONE = 2'h0;
  localparam logic [1:0] SUMMARY_SOME = 2'h1;
  localparam logic [1:0] SUMMARY_ALL = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rise;
    logic fall;
    logic byte_done;
    logic [7:0] data;
  } spi_evt_s;

  typedef struct packed {
    logic global_set;
    logic global_clr;
    logic sector_set;
    logic sector_clr;
    logic [4:0] sector_idx;
  } prot_req_s;

endpackage

// ---- core/sector_protect_bank.sv ----
// one volatile protection bit per sector, with global and single updates
// assumes requests are already gated by the locking logic
`timescale 1ns/1ps
`default_nettype none
module sector_protect_bank
(
  input wire logic clk,
  input wire logic rst,
  input wire sector_lock_pkg::prot_req_s req,
  output logic [sector_lock_pkg::SECTOR_COUNT-1:0] prot_q
);

  genvar i;
  generate
    for (i = 0; i < sector_lock_pkg::SECTOR_COUNT; i++)
    begin : g_sector
      logic hit;
      assign hit = (req.sector_idx == 5'(i));
      // power-up leaves every sector protected
      always_ff @(posedge clk)
      begin
        if (rst)
          prot_q[i] <= sector_lock_pkg::SECTOR_PROT_RESET;
        else if (req.global_set || (req.sector_set && hit))
          prot_q[i] <= 1'b1;
        else if (req.global_clr || (req.sector_clr && hit))
          prot_q[i] <= 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- core/sector_protection_lock.sv ----
// sector protection read command and hardware/software locking
// assumes an spi mode 0 host; pins synchronous to the 50 MHz clock
//
// Overview of operation
// - read protection: opcode 3Ch, three address bytes
// - output one bit on every serial clock falling edge after address
// - repeat FFh if protected, 00h otherwise
// - chip select release ends read, output floats
// - release accepted at any bit position
// - read value ignores write-protect pin level
// - each sector bit alone decides its protection
// - write-protect pin only acts on locking
// - hardware lock when pin low and lock set
// - hardware lock ignores protect, unprotect, status writes
// - clearing lock performs no global operation
// - pin low: lock clears only by power cycle
// - power-up: all protected, not locked
// - pin high: software lock, clearable, blocks sector commands
// - setting lock also applies decoded global operation
// - lock clear: sector and global commands accepted
// - summary bits report all, some or none
// - 00h unprotects, 7Fh protects, FFh protects and locks
// - bits 5..2 decoded only, bit 7 stored
`timescale 1ns/1ps
`default_nettype none
module sector_protection_lock
#(
  // opcode values for the commands that locking gates; plain defaults
  parameter logic [7:0] OP_WRITE_STATUS = 8'h01,
  parameter logic [7:0] OP_PROTECT_SECTOR = 8'h36,
  parameter logic [7:0] OP_UNPROTECT_SECTOR = 8'h39
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic protection_lock_bit,
  output logic [1:0] protection_summary_bits,
  output logic hw_locked
);

  // ----------------------------------------------------------------
  // command sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OPCODE = 5'h01,
    ST_ADDR = 5'h02,
    ST_STATUS = 5'h04,
    ST_READOUT = 5'h08,
    ST_IGNORE = 5'h10
  } cmd_state_e;

  typedef enum logic [2:0] {
    CMD_READ = 3'h1,
    CMD_PROTECT = 3'h2,
    CMD_UNPROTECT = 3'h4
  } addr_cmd_e;

  sector_lock_pkg::spi_evt_s evt;
  sector_lock_pkg::prot_req_s req;
  logic [sector_lock_pkg::SECTOR_COUNT-1:0] prot_q;

  cmd_state_e state_q;
  addr_cmd_e cmd_q;
  logic [1:0] addr_cnt_q;
  logic [4:0] sector_idx_q;
  logic lock_q;
  logic hw_lock;
  logic last_addr;
  logic [3:0] global_code;

  // ----------------------------------------------------------------
  // leaves
  // ----------------------------------------------------------------
  spi_byte_sampler u_sampler
  (
    .clk(clk),
    .rst(rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .evt(evt)
  );

  sector_protect_bank u_bank
  (
    .clk(clk),
    .rst(rst),
    .req(req),
    .prot_q(prot_q)
  );

  // ----------------------------------------------------------------
  // locking
  // ----------------------------------------------------------------
  // the pin never touches sector bits, it only qualifies the lock
  assign hw_lock = ~wp_n & lock_q;
  assign last_addr = (addr_cnt_q == 2'(sector_lock_pkg::ADDR_BYTES - 1));
  assign global_code =
    evt.data[sector_lock_pkg::GLOBAL_MSB:sector_lock_pkg::GLOBAL_LSB];

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || cs_n)
    begin
      state_q <= ST_OPCODE;
      cmd_q <= CMD_READ;
      addr_cnt_q <= 2'h0;
    end
    else if (evt.byte_done)
    begin
      case (state_q)
        ST_OPCODE:
        begin
          addr_cnt_q <= 2'h0;
          if (evt.data == sector_lock_pkg::OP_READ_PROTECTION)
          begin
            state_q <= ST_ADDR;
            cmd_q <= CMD_READ;
          end
          else if (evt.data == OP_PROTECT_SECTOR)
          begin
            state_q <= ST_ADDR;
            cmd_q <= CMD_PROTECT;
          end
          else if (evt.data == OP_UNPROTECT_SECTOR)
          begin
            state_q <= ST_ADDR;
            cmd_q <= CMD_UNPROTECT;
          end
          else if (evt.data == OP_WRITE_STATUS)
            state_q <= ST_STATUS;
          else
            state_q <= ST_IGNORE;
        end
        ST_ADDR:
        begin
          addr_cnt_q <= addr_cnt_q + 2'h1;
          if (last_addr)
            state_q <= (cmd_q == CMD_READ) ? ST_READOUT : ST_IGNORE;
        end
        ST_STATUS:
          state_q <= ST_IGNORE;
        ST_READOUT:
          state_q <= ST_READOUT;
        ST_IGNORE:
          state_q <= ST_IGNORE;
        default:
          state_q <= ST_IGNORE;
      endcase
    end
  end

  // first address byte carries A23..A16; low address bits are dropped
  always_ff @(posedge clk)
  begin
    if (rst)
      sector_idx_q <= 5'h00;
    else if (evt.byte_done && state_q == ST_ADDR && addr_cnt_q == 2'h0)
      sector_idx_q <= evt.data[sector_lock_pkg::SECTOR_IDX_W-1:0];
  end

  // ----------------------------------------------------------------
  // protection updates
  // ----------------------------------------------------------------
  always_comb
  begin
    req = '0;
    req.sector_idx = sector_idx_q;
    if (evt.byte_done && !hw_lock)
    begin
      // sector commands obeyed only while the lock bit is clear
      if (state_q == ST_ADDR && last_addr && !lock_q)
      begin
        req.sector_set = (cmd_q == CMD_PROTECT);
        req.sector_clr = (cmd_q == CMD_UNPROTECT);
      end
      // globals only from an unlocked state; clearing the lock never does
      if (state_q == ST_STATUS && !lock_q)
      begin
        req.global_set = (global_code == sector_lock_pkg::GLOBAL_PROTECT_CODE);
        req.global_clr =
          (global_code == sector_lock_pkg::GLOBAL_UNPROTECT_CODE);
      end
    end
  end

  // only bit 7 of the status byte is stored; bits 5..2 are decoded above
  always_ff @(posedge clk)
  begin
    if (rst)
      lock_q <= sector_lock_pkg::LOCK_RESET;
    else if (evt.byte_done && state_q == ST_STATUS && !hw_lock)
      lock_q <= evt.data[sector_lock_pkg::LOCK_BIT_POS];
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // every bit of the repeating byte equals the sector bit, so no byte
  // counter is needed and release mid-byte is harmless
  always_ff @(posedge clk)
  begin
    if (rst || cs_n)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else if (state_q == ST_READOUT && evt.fall)
    begin
      so <= prot_q[sector_idx_q];
      so_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      protection_summary_bits <= sector_lock_pkg::SUMMARY_ALL;
      protection_lock_bit <= sector_lock_pkg::LOCK_RESET;
      hw_locked <= 1'b0;
    end
    else
    begin
      if (&prot_q)
        protection_summary_bits <= sector_lock_pkg::SUMMARY_ALL;
      else if (|prot_q)
        protection_summary_bits <= sector_lock_pkg::SUMMARY_SOME;
      else
        protection_summary_bits <= sector_lock_pkg::SUMMARY_NONE;
      protection_lock_bit <= lock_q;
      hw_locked <= hw_lock;
    end
  end

endmodule
`default_nettype wire

// ---- core/spi_byte_sampler.sv ----
// serial clock edge detection and byte assembly for an spi mode 0 slave
// assumes sck, cs_n and si are already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module spi_byte_sampler
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output sector_lock_pkg::spi_evt_s evt
);

  logic sck_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end

  always_comb
  begin
    evt.rise = sck & ~sck_q & ~cs_n;
    evt.fall = ~sck & sck_q & ~cs_n;
    evt.byte_done = evt.rise & (bit_cnt_q == 3'h7);
    evt.data = {shift_q, si};
  end

  // cs release restarts byte framing at any bit position
  always_ff @(posedge clk)
  begin
    if (rst || cs_n)
    begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end
    else if (evt.rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= {shift_q[5:0], si};
    end
  end

endmodule
`default_nettype wire
